// ==== gesture_config_offset_regs.sv ====
// Gesture gain, drive, wait and crosstalk offset register bank with wait sequencer.
`timescale 1ns/1ps
// Overview of operation
// - Bits 6:5 select gain 1x to 8x.
// - Bits 4:3 select LED current 100-12.5 mA.
// - Bits 2:0 select wait 0 to 39.2 ms.
// - LED stays on about 1.33 us longer.
// - Separate 8-bit offset per photodiode channel.
// - Offsets are sign/magnitude, -127 to 127.
module gesture_config_offset_regs #(
  parameter int WAIT_STEP_CYCLES = gesture_cfg_pkg::WAIT_STEP_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic        [7:0]  reg_addr,
  input  wire logic               reg_wr,
  input  wire logic        [7:0]  reg_wdata,
  input  wire logic               reg_rd,
  output logic             [7:0]  reg_rdata,
  input  wire logic               gesture_engine_on,
  input  wire logic               cycle_done,
  input  wire logic               integ_active,
  output logic             [1:0]  gesture_gain_sel,
  output logic             [3:0]  gesture_gain_mult,
  output logic             [1:0]  gesture_led_current_sel,
  output logic             [7:0]  led_current_half_ma,
  output logic             [2:0]  gesture_wait_sel,
  output logic                    cycle_start,
  output logic                    wait_active,
  output logic                    led_sink_pin,
  output logic             [7:0]  up_offset_value,
  output logic             [7:0]  down_offset_value,
  output logic             [7:0]  left_offset_value,
  output logic             [7:0]  right_offset_value,
  output logic signed      [7:0]  up_correction,
  output logic signed      [7:0]  down_correction,
  output logic signed      [7:0]  left_correction,
  output logic signed      [7:0]  right_correction
);

  localparam int STEP_W = $clog2(WAIT_STEP_CYCLES);
  localparam int LED_W  = $clog2(gesture_cfg_pkg::LED_EXTRA_CYCLES + 1);
  localparam logic [STEP_W-1:0] STEP_LOAD = STEP_W'(WAIT_STEP_CYCLES - 1);
  localparam logic [LED_W-1:0]  LED_LOAD  = LED_W'(gesture_cfg_pkg::LED_EXTRA_CYCLES);

  typedef struct packed {
    logic [7:0]                cfg;
    logic [3:0][7:0]           offs;
    logic [3:0][7:0]           corr;
    logic [7:0]                rdata;
    logic [3:0]                gain_mult;
    logic [7:0]                half_ma;
    gesture_cfg_pkg::phase_e   phase;
    logic                      cycle_start;
    logic                      wait_active;
    logic [STEP_W-1:0]         step_cnt;
    logic [3:0]                steps_left;
    logic                      led_on;
    logic [LED_W-1:0]          led_cnt;
  } state_s;

  state_s           s;
  state_s           next_s;
  logic [3:0][7:0]  corr_new;
  logic [3:0][7:0]  offs_new;

  // Each offset as it will stand after this edge, kept apart from next_s so the decoders form no loop.
  // per-channel offset store
  always_comb
  begin
    for (int ch = 0; ch < gesture_cfg_pkg::CHANNELS; ch++)
      offs_new[ch] = (reg_wr && reg_addr == gesture_cfg_pkg::OFFSET_ADDRS[ch]) ? reg_wdata : s.offs[ch];
  end

  // Offsets are decoded from the value being stored, so code and factor change together.
  for (genvar ch = 0; ch < gesture_cfg_pkg::CHANNELS; ch++)
  begin : g_decode
    offset_decode u_decode (
      .code   (offs_new[ch]),
      .factor (corr_new[ch])
    );
  end

  // Register writes, registered reads, sequencer and LED overrun.
  always_comb
  begin
    next_s = s;
    next_s.cycle_start = 1'b0;
    if (reg_wr && reg_addr == gesture_cfg_pkg::ADDR_GAIN_DRIVE_WAIT)
    begin
      next_s.cfg = reg_wdata & gesture_cfg_pkg::CFG_WRITE_MASK;
    end
    next_s.offs = offs_new;
    next_s.corr = corr_new;
    next_s.gain_mult = gesture_cfg_pkg::gain_mult(next_s.cfg[gesture_cfg_pkg::GAIN_MSB:gesture_cfg_pkg::GAIN_LSB]);
    next_s.half_ma = gesture_cfg_pkg::led_half_ma(
      next_s.cfg[gesture_cfg_pkg::DRIVE_MSB:gesture_cfg_pkg::DRIVE_LSB]);
    // Reads return the stored value one cycle later; unmapped addresses read zero.
    if (reg_rd)
    begin
      next_s.rdata = gesture_cfg_pkg::UNMAPPED_READ;
      if (reg_addr == gesture_cfg_pkg::ADDR_GAIN_DRIVE_WAIT)
      begin
        next_s.rdata = s.cfg;
      end
      for (int ch = 0; ch < gesture_cfg_pkg::CHANNELS; ch++)
      begin
        if (reg_addr == gesture_cfg_pkg::OFFSET_ADDRS[ch])
        begin
          next_s.rdata = s.offs[ch];
        end
      end
    end
    case (s.phase)
      gesture_cfg_pkg::PH_IDLE:
      begin
        if (gesture_engine_on)
        begin
          next_s.phase = gesture_cfg_pkg::PH_MEASURE;
          next_s.cycle_start = 1'b1;
        end
      end
      gesture_cfg_pkg::PH_MEASURE:
      begin
        if (!gesture_engine_on)
        begin
          next_s.phase = gesture_cfg_pkg::PH_IDLE;
        end
        else if (cycle_done)
        begin
          next_s.steps_left = gesture_cfg_pkg::wait_steps(
            s.cfg[gesture_cfg_pkg::WAIT_MSB:gesture_cfg_pkg::WAIT_LSB]);
          if (next_s.steps_left == 4'h0)
          begin
            next_s.cycle_start = 1'b1;
          end
          else
          begin
            next_s.phase = gesture_cfg_pkg::PH_WAIT;
            next_s.wait_active = 1'b1;
            next_s.step_cnt = STEP_LOAD;
          end
        end
      end
      gesture_cfg_pkg::PH_WAIT:
      begin
        if (!gesture_engine_on)
        begin
          next_s.phase = gesture_cfg_pkg::PH_IDLE;
          next_s.wait_active = 1'b0;
        end
        else if (s.step_cnt != '0)
        begin
          next_s.step_cnt = s.step_cnt - 1'b1;
        end
        else if (s.steps_left == 4'h1)
        begin
          next_s.phase = gesture_cfg_pkg::PH_MEASURE;
          next_s.wait_active = 1'b0;
          next_s.cycle_start = 1'b1;
        end
        else
        begin
          next_s.steps_left = s.steps_left - 4'h1;
          next_s.step_cnt = STEP_LOAD;
        end
      end
      default:
      begin
        next_s.phase = gesture_cfg_pkg::PH_IDLE;
        next_s.wait_active = 1'b0;
      end
    endcase
    if (integ_active)
    begin
      next_s.led_on = 1'b1;
      next_s.led_cnt = LED_LOAD;
    end
    else if (s.led_cnt != '0)
    begin
      next_s.led_on = 1'b1;
      next_s.led_cnt = s.led_cnt - 1'b1;
    end
    else
    begin
      next_s.led_on = 1'b0;
    end
  end

  // State register; reset values are arbitrary zeros since none are specified, except gain_mult 1 and half_ma 8'hc8 to match cfg 0.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '{cfg: gesture_cfg_pkg::CFG_RESET, offs: {4{gesture_cfg_pkg::OFFSET_RESET}}, corr: '0,
             rdata: '0, gain_mult: 4'h1, half_ma: 8'hc8, phase: gesture_cfg_pkg::PH_IDLE,
             cycle_start: 1'b0, wait_active: 1'b0, step_cnt: '0, steps_left: 4'h0,
             led_on: 1'b0, led_cnt: '0};
    end
    else
    begin
      s <= next_s;
    end
  end

  // Every output is a field of the state register.
  assign reg_rdata               = s.rdata;
  assign gesture_gain_sel        = s.cfg[gesture_cfg_pkg::GAIN_MSB:gesture_cfg_pkg::GAIN_LSB];
  assign gesture_gain_mult       = s.gain_mult;
  assign gesture_led_current_sel = s.cfg[gesture_cfg_pkg::DRIVE_MSB:gesture_cfg_pkg::DRIVE_LSB];
  assign led_current_half_ma     = s.half_ma;
  assign gesture_wait_sel        = s.cfg[gesture_cfg_pkg::WAIT_MSB:gesture_cfg_pkg::WAIT_LSB];
  assign cycle_start             = s.cycle_start;
  assign wait_active             = s.wait_active;
  assign led_sink_pin            = s.led_on;
  assign up_offset_value         = s.offs[0];
  assign down_offset_value       = s.offs[1];
  assign left_offset_value       = s.offs[2];
  assign right_offset_value      = s.offs[3];
  assign up_correction           = s.corr[0];
  assign down_correction         = s.corr[1];
  assign left_correction         = s.corr[2];
  assign right_correction        = s.corr[3];

  // Helper logic for the checks: wait length and time since integration ended.
  logic [23:0] wait_len;
  logic [23:0] wait_expect;
  logic [7:0]  low_run;
  logic        seen_integ;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_len <= '0;
      wait_expect <= '0;
      low_run <= '0;
      seen_integ <= 1'b0;
    end
    else
    begin
      wait_len <= next_s.wait_active ? wait_len + 24'h1 : 24'h0;
      if (next_s.wait_active && !s.wait_active)
      begin
        wait_expect <= 24'(int'(next_s.steps_left) * WAIT_STEP_CYCLES);
      end
      seen_integ <= seen_integ | integ_active;
      low_run <= integ_active ? 8'h00 : (low_run == 8'hff ? low_run : low_run + 8'h01);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_rsvd_reads_zero: assert property (reg_rd && reg_addr == gesture_cfg_pkg::ADDR_GAIN_DRIVE_WAIT |=> !reg_rdata[7])
    else $error("reserved bit read as one");
  a_gain_write: assert property (reg_wr && reg_addr == gesture_cfg_pkg::ADDR_GAIN_DRIVE_WAIT |=>
    gesture_gain_sel == $past(reg_wdata[6:5]) && gesture_gain_mult == (4'h1 << gesture_gain_sel))
    else $error("gain select or multiplier wrong after write");
  a_drive_write: assert property (reg_wr && reg_addr == gesture_cfg_pkg::ADDR_GAIN_DRIVE_WAIT |=>
    gesture_led_current_sel == $past(reg_wdata[4:3]))
    else $error("LED current select wrong after write");
  a_drive_current: assert property (gesture_led_current_sel == 2'h3 |-> led_current_half_ma == 8'h19)
    else $error("lowest LED current not 12.5 mA");
  a_wait_zero: assert property (s.phase == gesture_cfg_pkg::PH_MEASURE && gesture_engine_on && cycle_done &&
    gesture_wait_sel == 3'h0 |=> cycle_start && !wait_active)
    else $error("zero wait did not restart at once");
  a_wait_length: assert property ($fell(wait_active) && cycle_start |-> $past(wait_len) == wait_expect)
    else $error("wait length differs from selected time");
  a_led_overrun: assert property (seen_integ |-> led_sink_pin == (low_run <= 8'(LED_LOAD)))
    else $error("LED on time not integration plus overrun");
  a_offset_store: assert property (reg_wr && reg_addr == gesture_cfg_pkg::ADDR_LEFT_OFFSET |=>
    left_offset_value == $past(reg_wdata) && $stable(up_offset_value))
    else $error("left offset not stored alone");
  a_offset_sign: assert property (right_offset_value[7] && right_offset_value[6:0] != 7'h00 |->
    right_correction == -$signed({1'b0, right_offset_value[6:0]}))
    else $error("negative offset decoded wrongly");
  a_negative_zero: assert property (down_offset_value[6:0] == 7'h00 |-> down_correction == 8'sh00)
    else $error("negative zero offset not zero");

  c_wait_entered: cover property ($rose(wait_active));
  c_wait_restart: cover property ($fell(wait_active) && cycle_start);
  c_led_overrun: cover property ($fell(integ_active) ##1 led_sink_pin [*3]);
  c_negative_offset: cover property (up_correction < 8'sh00);

endmodule : gesture_config_offset_regs

// ==== gesture_cfg_pkg.sv ====
// Shared constants, decode functions and types for the gesture configuration bank.
package gesture_cfg_pkg;

  // Register addresses on the sensor's register port.
  localparam logic [7:0] ADDR_GAIN_DRIVE_WAIT = 8'ha3;
  localparam logic [7:0] ADDR_UP_OFFSET       = 8'ha4;
  localparam logic [7:0] ADDR_DOWN_OFFSET     = 8'ha5;
  localparam logic [7:0] ADDR_LEFT_OFFSET     = 8'ha7;
  localparam logic [7:0] ADDR_RIGHT_OFFSET    = 8'ha9;

  // Channel order is up, down, left, right.
  localparam int                CHANNELS     = 4;
  localparam logic [3:0][7:0]   OFFSET_ADDRS = {ADDR_RIGHT_OFFSET, ADDR_LEFT_OFFSET,
                                                ADDR_DOWN_OFFSET, ADDR_UP_OFFSET};

  // Field positions of the gain, drive and wait register.
  localparam int GAIN_LSB  = 5;
  localparam int GAIN_MSB  = 6;
  localparam int DRIVE_LSB = 3;
  localparam int DRIVE_MSB = 4;
  localparam int WAIT_LSB  = 0;
  localparam int WAIT_MSB  = 2;
  localparam int SIGN_BIT  = 7;

  // Bit 7 of the configuration register is reserved and never stored.
  localparam logic [7:0] CFG_WRITE_MASK = 8'h7f;
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam logic [7:0] OFFSET_RESET   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // Timing: clock rate, wait step and LED overrun time.
  localparam int CLK_MHZ          = 20;
  localparam int WAIT_STEP_US     = 2800;
  localparam int WAIT_STEP_CYCLES = WAIT_STEP_US * CLK_MHZ;
  localparam int LED_EXTRA_NS     = 1330;
  localparam int LED_EXTRA_CYCLES = (LED_EXTRA_NS * CLK_MHZ + 999) / 1000;

  // Gain multiplier for a gain select code: 1x, 2x, 4x, 8x.
  function automatic logic [3:0] gain_mult(input logic [1:0] sel);
    gain_mult = 4'h1 << sel;
  endfunction : gain_mult

  // LED current in half-milliamp units: 100, 50, 25 and 12.5 mA.
  function automatic logic [7:0] led_half_ma(input logic [1:0] sel);
    case (sel)
      2'h0:    led_half_ma = 8'hc8;
      2'h1:    led_half_ma = 8'h64;
      2'h2:    led_half_ma = 8'h32;
      default: led_half_ma = 8'h19;
    endcase
  endfunction : led_half_ma

  // Wait time in 2.8 ms steps: 0, 2.8, 5.6, 8.4, 14.0, 22.4, 30.8, 39.2 ms.
  function automatic logic [3:0] wait_steps(input logic [2:0] sel);
    case (sel)
      3'h0:    wait_steps = 4'h0;
      3'h1:    wait_steps = 4'h1;
      3'h2:    wait_steps = 4'h2;
      3'h3:    wait_steps = 4'h3;
      3'h4:    wait_steps = 4'h5;
      3'h5:    wait_steps = 4'h8;
      3'h6:    wait_steps = 4'hb;
      default: wait_steps = 4'he;
    endcase
  endfunction : wait_steps

  // Phases of the detection and wait sequencer.
  typedef enum logic [1:0] {PH_IDLE, PH_MEASURE, PH_WAIT} phase_e;

endpackage : gesture_cfg_pkg

// ==== offset_decode.sv ====
// Sign/magnitude offset code to two's complement correction factor.
`timescale 1ns/1ps
module offset_decode (
  input  wire logic        [7:0] code,
  output logic signed      [7:0] factor
);

  logic [6:0] magnitude;

  // A negative zero is folded onto zero so both codes correct nothing.
  always_comb
  begin
    magnitude = code[6:0];
    if (magnitude == 7'h00)
    begin
      factor = 8'sh00;
    end
    else if (code[gesture_cfg_pkg::SIGN_BIT])
    begin
      factor = -$signed({1'b0, magnitude});
    end
    else
    begin
      factor = $signed({1'b0, magnitude});
    end
  end

endmodule : offset_decode

// ==== reg_host.sv ====
// Host controller model driving the sensor's register port.
`timescale 1ns/1ps
module reg_host (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  // Strobes start low so nothing is taken during reset.
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // Released address and data lines show the inverse of the last value, so sampling them late is caught.
  task automatic release_bus();
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : release_bus

  // One-cycle write strobe, launched and released on falling edges.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(negedge clk);
    release_bus();
  endtask : write_reg

  // Read data is registered, so it is settled one falling edge after the strobe.
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk);
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(negedge clk);
    release_bus();
    data = reg_rdata;
  endtask : read_reg
endmodule : reg_host

// ==== tb.sv ====
// Self-checking testbench for the gesture configuration and offset bank.
`timescale 1ns/1ps
module tb;
  // A short wait step keeps the longest wait at 56 cycles.
  localparam int         STEP = 4;
  localparam logic [7:0] CFG  = gesture_cfg_pkg::ADDR_GAIN_DRIVE_WAIT;
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            gesture_engine_on = 1'b0;
  logic            cycle_done = 1'b0;
  logic            integ_active = 1'b0;
  logic [7:0]      reg_addr, reg_wdata, reg_rdata, led_current_half_ma;
  logic            reg_wr, reg_rd, cycle_start, wait_active, led_sink_pin;
  logic [1:0]      gesture_gain_sel, gesture_led_current_sel;
  logic [3:0]      gesture_gain_mult;
  logic [2:0]      gesture_wait_sel;
  logic [3:0][7:0] ofs, cor;
  int              num_errors = 0;
  int              n_compared = 0;
  logic [7:0]      half_ma [4] = '{8'hc8, 8'h64, 8'h32, 8'h19};
  int              steps [8] = '{0, 1, 2, 3, 5, 8, 11, 14};
  logic [7:0]      codes [6] = '{8'h7f, 8'h01, 8'h00, 8'h81, 8'hff, 8'h80};
  logic [7:0]      factors [6] = '{8'h7f, 8'h01, 8'h00, 8'hff, 8'h81, 8'h00};

  // Clock of 50 ns period.
  always #25 clk = ~clk;

  gesture_config_offset_regs #(.WAIT_STEP_CYCLES(STEP)) gesture_config_offset_regs_inst (
    .clk(clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .gesture_engine_on(gesture_engine_on),
    .cycle_done(cycle_done),
    .integ_active(integ_active),
    .gesture_gain_sel(gesture_gain_sel),
    .gesture_gain_mult(gesture_gain_mult),
    .gesture_led_current_sel(gesture_led_current_sel),
    .led_current_half_ma(led_current_half_ma),
    .gesture_wait_sel(gesture_wait_sel),
    .cycle_start(cycle_start),
    .wait_active(wait_active),
    .led_sink_pin(led_sink_pin),
    .up_offset_value(ofs[0]),
    .down_offset_value(ofs[1]),
    .left_offset_value(ofs[2]),
    .right_offset_value(ofs[3]),
    .up_correction(cor[0]),
    .down_correction(cor[1]),
    .left_correction(cor[2]),
    .right_correction(cor[3])
  );

  reg_host reg_host_inst (
    .clk(clk),
    .reg_rdata(reg_rdata),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd)
  );

  // Case inequality so an unknown never passes.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Single exit point for the tests and the watchdog.
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // The run needs under a thousand cycles; this only cuts a hang short.
  initial
  begin
    #1000000;
    num_errors++;
    give_verdict();
  end

  // Main sequence of register and sequencer tests.
  initial
  begin
    logic [7:0] rv;
    int         cnt;
    int         wcnt;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    reg_host_inst.read_reg(CFG, rv);
    check("cfg reset", rv, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      reg_host_inst.write_reg(CFG, {1'b1, i[1:0], ~i[1:0], i[2:0]});
      check("gain sel", {6'h00, gesture_gain_sel}, {6'h00, i[1:0]});
      check("gain mult", {4'h0, gesture_gain_mult}, 8'h01 << i[1:0]);
      check("drive sel", {6'h00, gesture_led_current_sel}, {6'h00, ~i[1:0]});
      check("led current", led_current_half_ma, half_ma[~i[1:0]]);
      check("wait sel", {5'h00, gesture_wait_sel}, {5'h00, i[2:0]});
      reg_host_inst.read_reg(CFG, rv);
      check("cfg readback", rv, {1'b0, i[1:0], ~i[1:0], i[2:0]});
    end
    for (int j = 0; j < 6; j++)
    begin
      for (int c = 0; c < 4; c++)
        reg_host_inst.write_reg(gesture_cfg_pkg::OFFSET_ADDRS[c], codes[(j + c) % 6]);
      reg_host_inst.write_reg(j[0] ? 8'ha8 : 8'ha6, 8'h55);
      for (int c = 0; c < 4; c++)
      begin
        check("offset value", ofs[c], codes[(j + c) % 6]);
        check("correction", cor[c], factors[(j + c) % 6]);
        reg_host_inst.read_reg(gesture_cfg_pkg::OFFSET_ADDRS[c], rv);
        check("offset readback", rv, codes[(j + c) % 6]);
      end
      reg_host_inst.read_reg(8'ha6, rv);
      check("unmapped read", rv, 8'h00);
    end
    reg_host_inst.write_reg(CFG, 8'h00);
    gesture_engine_on = 1'b1;
    cnt = 0;
    while (cycle_start !== 1'b1 && cnt < 10)
    begin
      @(negedge clk);
      cnt++;
    end
    check("first start", {7'h00, cycle_start}, 8'h01);
    for (int w = 0; w < 8; w++)
    begin
      reg_host_inst.write_reg(CFG, {5'h00, w[2:0]});
      integ_active = 1'b1;
      cnt = 0;
      for (int i = 1; i <= 60; i++)
      begin
        @(negedge clk);
        if (i == 5)
          integ_active = 1'b0;
        if (led_sink_pin === 1'b1)
          cnt++;
      end
      check("led on time", 8'(cnt), 8'(5 + gesture_cfg_pkg::LED_EXTRA_CYCLES));
      cycle_done = 1'b1;
      @(negedge clk);
      cycle_done = 1'b0;
      cnt = 1;
      wcnt = 0;
      while (cycle_start !== 1'b1 && cnt < 200)
      begin
        if (wait_active === 1'b1)
          wcnt++;
        @(negedge clk);
        cnt++;
      end
      check("wait length", 8'(wcnt), 8'(steps[w] * STEP));
      check("restart delay", 8'(cnt), 8'(1 + steps[w] * STEP));
    end
    cycle_done = 1'b1;
    @(negedge clk);
    cycle_done = 1'b0;
    repeat (3) @(negedge clk);
    gesture_engine_on = 1'b0;
    repeat (2) @(negedge clk);
    check("abort wait", {7'h00, wait_active}, 8'h00);
    cnt = 0;
    repeat (70)
    begin
      @(negedge clk);
      if (cycle_start !== 1'b0)
        cnt++;
    end
    check("no restart", 8'(cnt), 8'h00);
    give_verdict();
  end
endmodule : tb
